/* hw/rkc_top.sv */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`default_nettype none
module rkc_top import rkc_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_parity_err,
  input wire logic open_channel,
  output logic resp_valid,
  output logic resp_err,
  output logic [7:0] resp_code,
  output logic [7:0] resp_addr,
  input wire logic rs485_char_valid,
  input wire logic rx_buf_empty,
  input wire logic modem_tx_idle,
  input wire logic modem_cts,
  output logic modem_rts,
  output logic tx_enable
);
  localparam int TDW = $clog2(MS_CYCLES);

  typedef struct packed {
    logic aw_ok, w_ok, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] setup;
    logic [2:0][DLY_W-1:0] dly;
    logic [7:0] sp;
    logic we;
    logic coll, perr, ovf;
    logic [7:0] pchar;
    logic [4:0] len;
    logic [CBUF_DEPTH-1:0][7:0] cbuf;
    logic resp_valid, resp_err;
    logic [7:0] resp_code;
    rkc_key_t kst;
    logic rts, tx_en;
    logic [2:0] tstart, tstop;
    logic [TDW-1:0] tdiv;
    logic ms_tick, cts_s1, cts_s2;
  } rkc_state_t;

  rkc_state_t st;
  rkc_state_t next_st;
  logic [2:0] tdone;
  rkc_tmr_if tif[3] ();

  for (genvar g = 0; g < 3; g++) begin : g_tmr
    assign tif[g].start = st.tstart[g];
    assign tif[g].stop = st.tstop[g];
    assign tif[g].value = st.dly[g];
    assign tdone[g] = tif[g].done;
    rkc_ms_timer u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .ms_tick(st.ms_tick),
      .ifc(tif[g])
    );
  end

  // command decode over the collected characters
  logic [15:0] mn;
  rkc_cmd_t ev_cmd;
  logic [4:0] expect_len, n_arg;
  logic cs_on, dig_ok, hex_ok, addr_bad, ev_fire;
  logic [7:0] sum, ev_code;
  logic [4:0] csh, csl, hx;
  logic [16:0] dval;
  logic [31:0] hval;
  // merged delay word of a bus write, kept apart from the decode's hex value
  logic [31:0] mrg;

  always_comb begin
    mn = {st.cbuf[1], st.cbuf[2]};
    ev_cmd = C_NONE;
    expect_len = '0;
    if (mn == MN_WE) begin
      ev_cmd = C_WE;
    end else if (mn == MN_T1 || mn == MN_T2 || mn == MN_T3) begin
      ev_cmd = (mn == MN_T1) ? C_T1 : (mn == MN_T2) ? C_T2 : C_T3;
      expect_len = 5'(ARG_T);
    end else if (mn == MN_SP) begin
      ev_cmd = C_SP;
      expect_len = 5'(ARG_SP);
    end else if (mn == MN_SU) begin
      ev_cmd = C_SU;
      expect_len = 5'(ARG_SU);
    end
    n_arg = st.len - 5'(ARG0);
    cs_on = n_arg == 5'(expect_len + 5'(CSUM_LEN));
    sum = st.pchar;
    for (int i = 0; i < CBUF_DEPTH; i++) begin
      if (5'(i) < st.len - 5'(CSUM_LEN)) sum = sum + st.cbuf[i];
    end
    csh = rkc_hex(st.cbuf[4'(st.len - 5'(CSUM_LEN))]);
    csl = rkc_hex(st.cbuf[4'(st.len - 5'(CSUM_LEN - 1))]);
    dval = '0;
    dig_ok = 1'b1;
    for (int k = 1; k < ARG_T; k++) begin
      if (k != T_DOT_POS) begin
        dig_ok &= st.cbuf[ARG0+k] >= CH_0 && st.cbuf[ARG0+k] <= CH_9;
      end
      if (k < T_DOT_POS) begin
        dval = 17'(dval * 17'd10) + 17'(4'(st.cbuf[ARG0+k] - CH_0));
      end
    end
    hval = '0;
    hex_ok = 1'b1;
    for (int i = 0; i < ARG_SU; i++) begin
      hx = rkc_hex(st.cbuf[ARG0+i]);
      if (5'(i) < expect_len) begin
        hex_ok &= hx[4];
        hval = {hval[27:0], hx[3:0]};
      end
    end
    addr_bad = hval[31:24] > ADDR_MAX || hval[31:24] == CH_NUL || hval[31:24] == CH_CR
      || hval[31:24] == CH_DOLLAR || hval[31:24] == CH_HASH
      || hval[31:24] == CH_LBRACE || hval[31:24] == CH_RBRACE;
    ev_code = RESP_OK;
    if (st.perr) begin
      ev_code = ERR_PAR;
    end else if (ev_cmd == C_NONE) begin
      ev_code = ERR_CMD;
    end else if (st.len < 5'(ARG0) || st.ovf || (n_arg != expect_len && !cs_on)) begin
      ev_code = ERR_SYN;
    end else if (cs_on && (!csh[4] || !csl[4] || {csh[3:0], csl[3:0]} != sum)) begin
      ev_code = ERR_CSUM;
    end else if (expect_len == 5'(ARG_T)
                 && (st.cbuf[ARG0] != CH_PLUS || st.cbuf[ARG0+T_DOT_POS] != CH_DOT)) begin
      ev_code = ERR_SYN;
    end else if (ev_cmd != C_WE && !st.we) begin
      ev_code = ERR_WP;
    end else if (expect_len == 5'(ARG_T) ? (!dig_ok || dval > 17'(DLY_MAX_MS)) : !hex_ok) begin
      ev_code = ERR_VAL;
    end else if (ev_cmd == C_SU && addr_bad) begin
      ev_code = ERR_ADDR;
    end
    ev_fire = cmd_valid && cmd_data == CH_CR && st.coll && st.len != '0
      && st.cbuf[0] == st.setup[SETUP_ADDR_LSB +: 8];
  end

  always_comb begin
    next_st = st;
    mrg = '0;
    next_st.resp_valid = 1'b0;
    next_st.tstart = '0;
    next_st.tstop = '0;
    next_st.cts_s1 = modem_cts;
    next_st.cts_s2 = st.cts_s1;
    next_st.ms_tick = st.tdiv == TDW'(MS_CYCLES - 1);
    next_st.tdiv = next_st.ms_tick ? '0 : st.tdiv + TDW'(1);
    // register bus: write address and data in either order
    if (st.awready && s_axi_awvalid) begin
      next_st.aw_ok = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid) begin
      next_st.w_ok = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_ok && st.w_ok && !st.bvalid) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = AXI_OKAY;
      unique case ({st.awaddr[7:2], 2'b00})
        REG_SETUP: next_st.setup = rkc_merge(st.setup, st.wdata, st.wstrb);
        REG_T1, REG_T2, REG_T3: begin
          mrg = rkc_merge(32'(st.dly[st.awaddr[3:2] - 2'd1]), st.wdata, st.wstrb);
          if (mrg <= 32'(DLY_MAX_MS)) begin
            next_st.dly[st.awaddr[3:2] - 2'd1] = DLY_W'(mrg);
          end
        end
        REG_SPROMPT: next_st.sp = 8'(rkc_merge(32'(st.sp), st.wdata, st.wstrb));
        REG_STATUS: next_st.bresp = AXI_OKAY;
        default: next_st.bresp = AXI_SLVERR;
      endcase
    end
    next_st.awready = !next_st.aw_ok && !next_st.bvalid;
    next_st.wready = !next_st.w_ok && !next_st.bvalid;
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (st.arready && s_axi_arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = AXI_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        REG_SETUP: next_st.rdata = st.setup;
        REG_T1: next_st.rdata = 32'(st.dly[0]);
        REG_T2: next_st.rdata = 32'(st.dly[1]);
        REG_T3: next_st.rdata = 32'(st.dly[2]);
        REG_SPROMPT: next_st.rdata = 32'(st.sp);
        REG_STATUS: next_st.rdata = {13'h0000, st.kst, st.resp_code, 5'h00,
                                     st.we, st.tx_en, st.rts};
        default: begin
          next_st.rdata = '0;
          next_st.rresp = AXI_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;
    // command collection
    if (cmd_valid) begin
      if (cmd_data == CH_DOLLAR || cmd_data == CH_HASH
          || (st.setup[SETUP_EXT_BIT] && cmd_data == st.sp)) begin
        next_st.coll = 1'b1;
        next_st.pchar = cmd_data;
        next_st.len = '0;
        next_st.ovf = 1'b0;
        next_st.perr = cmd_parity_err && st.setup[SETUP_PAR_EN_BIT];
      end else if (st.coll && cmd_data == CH_CR) begin
        next_st.coll = 1'b0;
      end else if (st.coll) begin
        next_st.perr = st.perr || (cmd_parity_err && st.setup[SETUP_PAR_EN_BIT]);
        if (st.len == 5'(CBUF_DEPTH)) begin
          next_st.ovf = 1'b1;
        end else begin
          next_st.cbuf[4'(st.len)] = cmd_data;
          next_st.len = st.len + 5'd1;
        end
      end
    end
    if (ev_fire) begin
      next_st.resp_valid = 1'b1;
      next_st.resp_code = ev_code;
      next_st.resp_err = ev_code != RESP_OK;
      if (ev_code == RESP_OK) begin
        next_st.we = ev_cmd == C_WE;
        unique case (ev_cmd)
          C_T1: next_st.dly[0] = DLY_W'(dval);
          C_T2: next_st.dly[1] = DLY_W'(dval);
          C_T3: next_st.dly[2] = DLY_W'(dval);
          C_SP: next_st.sp = hval[7:0];
          C_SU: next_st.setup = hval;
          default: next_st.we = next_st.we;
        endcase
      end
    end else if (open_channel && st.setup[SETUP_EXT_BIT]) begin
      next_st.resp_valid = 1'b1;
      next_st.resp_err = st.sp == CH_NUL || st.sp == CH_CR
        || st.sp == CH_HASH || st.sp == CH_DOLLAR;
      next_st.resp_code = next_st.resp_err ? ERR_CMD : RESP_OK;
    end
    // radio keying sequence
    unique case (st.kst)
      K_IDLE: if (rs485_char_valid) begin
        next_st.tstart[0] = 1'b1;
        next_st.kst = K_DEAD;
      end
      K_DEAD: if (rs485_char_valid) begin
        next_st.tstart[0] = 1'b1;
      end else if (tdone[0] && !st.tstart[0]) begin
        next_st.rts = 1'b1;
        next_st.tstart[1] = 1'b1;
        next_st.kst = K_SETTLE;
      end
      K_SETTLE: if (st.cts_s2 || (tdone[1] && !st.tstart[1])) begin
        next_st.tstop[1] = 1'b1;
        next_st.tx_en = 1'b1;
        next_st.kst = K_SEND;
      end
      K_SEND: if (rx_buf_empty && modem_tx_idle) begin
        next_st.tstart[2] = 1'b1;
        next_st.kst = K_HOLD;
      end
      K_HOLD: if (!rx_buf_empty) begin
        next_st.tstop[2] = 1'b1;
        next_st.kst = K_SEND;
      end else if (tdone[2] && !st.tstart[2]) begin
        next_st.rts = 1'b0;
        next_st.tx_en = 1'b0;
        next_st.kst = K_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.setup <= SETUP_RST;
      st.dly <= {T3_RST, T2_RST, T1_RST};
      st.sp <= SP_RST;
      st.kst <= K_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign resp_valid = st.resp_valid;
  assign resp_err = st.resp_err;
  assign resp_code = st.resp_code;
  assign resp_addr = st.setup[SETUP_ADDR_LSB +: 8];
  assign modem_rts = st.rts;
  assign tx_enable = st.tx_en;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_dead_start;
    st.kst == K_IDLE && rs485_char_valid |=> st.kst == K_DEAD ##1 tif[0].busy || tdone[0];
  endproperty
  a_dead_start: assert property (p_dead_start) else $error("dead time not started");
  property p_rts_on;
    st.kst == K_DEAD && !rs485_char_valid && tdone[0] && !st.tstart[0]
      |=> modem_rts && st.kst == K_SETTLE;
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not raised");
  property p_cts_cut;
    st.kst == K_SETTLE && st.cts_s2 |=> tx_enable ##1 !tif[1].busy;
  endproperty
  a_cts_cut: assert property (p_cts_cut) else $error("cts did not end settle");
  property p_hold_start;
    st.kst == K_SEND && rx_buf_empty && modem_tx_idle |=> st.kst == K_HOLD && modem_rts;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold not started");
  property p_hold_cancel;
    st.kst == K_HOLD && !rx_buf_empty |=> st.kst == K_SEND && tx_enable;
  endproperty
  a_hold_cancel: assert property (p_hold_cancel) else $error("hold not cancelled");
  property p_rts_off;
    st.kst == K_HOLD && rx_buf_empty && tdone[2] && !st.tstart[2] |=> !modem_rts && !tx_enable;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("rts not dropped");
  property p_we_arm;
    ev_fire && ev_code == RESP_OK && ev_cmd == C_WE |=> st.we && resp_code == RESP_OK;
  endproperty
  a_we_arm: assert property (p_we_arm) else $error("write enable not armed");
  property p_we_clear;
    ev_fire && ev_code == RESP_OK && ev_cmd != C_WE |=> !st.we;
  endproperty
  a_we_clear: assert property (p_we_clear) else $error("write enable not cleared");
  property p_we_keep;
    ev_fire && ev_code != RESP_OK && st.we |=> st.we && resp_err;
  endproperty
  a_we_keep: assert property (p_we_keep) else $error("write enable lost on error");
  property p_addr_keep;
    ev_fire && ev_code == ERR_ADDR |=> $stable(st.setup) && resp_code == ERR_ADDR;
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("setup changed on bad address");
  property p_par_gate;
    ev_fire && !st.setup[SETUP_PAR_EN_BIT] |-> ev_code != ERR_PAR;
  endproperty
  a_par_gate: assert property (p_par_gate) else $error("parity error while disabled");
  property p_dly_max;
    st.dly[0] <= DLY_MAX_MS && st.dly[1] <= DLY_MAX_MS && st.dly[2] <= DLY_MAX_MS;
  endproperty
  a_dly_max: assert property (p_dly_max) else $error("delay above limit");
endmodule
`default_nettype wire

/* hw/rkc_pkg.sv */
`default_nettype none
package rkc_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DLY_W = 11;
  localparam logic [DLY_W-1:0] DLY_MAX_MS = 11'h7d0;
  localparam logic [7:0] REG_SETUP = 8'h00;
  localparam logic [7:0] REG_T1 = 8'h04;
  localparam logic [7:0] REG_T2 = 8'h08;
  localparam logic [7:0] REG_T3 = 8'h0c;
  localparam logic [7:0] REG_SPROMPT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [31:0] SETUP_RST = 32'h31050000;
  localparam logic [DLY_W-1:0] T1_RST = 11'h064;
  localparam logic [DLY_W-1:0] T2_RST = 11'h1f4;
  localparam logic [DLY_W-1:0] T3_RST = 11'h032;
  localparam logic [7:0] SP_RST = 8'h7b;
  localparam int SETUP_ADDR_LSB = 24;
  localparam int SETUP_PAR_EN_BIT = 21;
  localparam int SETUP_EXT_BIT = 8;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_LBRACE = 8'h7b;
  localparam logic [7:0] CH_RBRACE = 8'h7d;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] HEX_TEN = 8'h0a;
  localparam logic [7:0] ADDR_MAX = 8'h7f;
  localparam logic [15:0] MN_WE = 16'h5745;
  localparam logic [15:0] MN_T1 = 16'h5431;
  localparam logic [15:0] MN_T2 = 16'h5432;
  localparam logic [15:0] MN_T3 = 16'h5433;
  localparam logic [15:0] MN_SP = 16'h5350;
  localparam logic [15:0] MN_SU = 16'h5355;
  localparam logic [7:0] RESP_OK = 8'h2a;
  localparam logic [7:0] ERR_ADDR = 8'h41;
  localparam logic [7:0] ERR_CSUM = 8'h42;
  localparam logic [7:0] ERR_CMD = 8'h43;
  localparam logic [7:0] ERR_PAR = 8'h50;
  localparam logic [7:0] ERR_SYN = 8'h53;
  localparam logic [7:0] ERR_VAL = 8'h56;
  localparam logic [7:0] ERR_WP = 8'h57;
  localparam int CBUF_DEPTH = 16;
  localparam int ARG0 = 3;
  localparam int ARG_T = 9;
  localparam int ARG_SP = 2;
  localparam int ARG_SU = 8;
  localparam int CSUM_LEN = 2;
  localparam int T_DOT_POS = 6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {K_IDLE, K_DEAD, K_SETTLE, K_SEND, K_HOLD} rkc_key_t;
  typedef enum logic [2:0] {C_NONE, C_WE, C_T1, C_T2, C_T3, C_SP, C_SU} rkc_cmd_t;

  function automatic logic [4:0] rkc_hex(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= CH_0 && c <= CH_9) begin
      r = {1'b1, 4'(c - CH_0)};
    end else if (c >= CH_A && c <= CH_F) begin
      r = {1'b1, 4'(c - CH_A + HEX_TEN)};
    end
    return r;
  endfunction

  function automatic logic [31:0] rkc_merge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* hw/rkc_tmr_if.sv */
`default_nettype none
interface rkc_tmr_if import rkc_pkg::*;;
  logic start;
  logic stop;
  logic [DLY_W-1:0] value;
  logic done;
  logic busy;
  modport ctl(output start, output stop, output value, input done, input busy);
  modport tmr(input start, input stop, input value, output done, output busy);
endinterface
`default_nettype wire

/* hw/rkc_ms_timer.sv */
`default_nettype none
module rkc_ms_timer import rkc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ms_tick,
  rkc_tmr_if.tmr ifc
);
  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic busy;
    logic done;
  } rkc_tmr_st_t;

  rkc_tmr_st_t st;
  rkc_tmr_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (ifc.stop) begin
      next_st.busy = 1'b0;
    end
    if (ifc.start) begin
      // zero delay expires on the next edge
      next_st.cnt = ifc.value;
      next_st.busy = ifc.value != '0;
      next_st.done = ifc.value == '0;
    end else if (st.busy && ms_tick) begin
      if (st.cnt == DLY_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - DLY_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ifc.done = st.done;
  assign ifc.busy = st.busy;
endmodule
`default_nettype wire

/* tb/rkc_modem_model.sv */
`default_nettype none
module rkc_modem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic modem_rts,
  input wire logic tx_enable,
  input wire logic load,
  input wire logic [3:0] load_n,
  input wire logic cts_on,
  output logic modem_cts,
  output logic rx_buf_empty,
  output logic modem_tx_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pend;
  logic [2:0] shift;
  // clear-to-send only while keyed
  assign modem_cts = cts_on & modem_rts;
  assign rx_buf_empty = (pend == 4'h0);
  assign modem_tx_idle = (shift == 3'h0);
  // one character leaves every eight cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 4'h0;
      shift <= 3'h0;
    end else if (load) begin
      pend <= pend + load_n;
    end else if (tx_enable && pend != 4'h0 && shift == 3'h0) begin
      pend <= pend - 4'h1;
      shift <= 3'h7;
    end else if (shift != 3'h0) begin
      shift <= shift - 3'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/radio_keying_command_checker_bench.sv */
`default_nettype none
`define CHK(n, e, s) begin \
  checks++; \
  if ((s) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, s); \
  end \
end
`define WT(c, l) begin \
  for (waited = 0; waited < (l) && (c) !== 1'h1; waited++) @(posedge aclk); \
  gate((c) === 1'h1); \
end
module radio_keying_command_checker_bench import rkc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic cmd_valid = 1'h0, par = 1'h0, cts_on = 1'h0;
  logic [2:0] pl = 3'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cmd_data = 8'h00, resp_code, resp_addr;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic awready, wready, bvalid, arready, rvalid, resp_valid, resp_err, rts, txe, cts;
  logic empty, idle;
  int failures = 0, checks = 0, seed = 86631, waited, v, k;
  string seq[] = '{"$1T1+00010.00", "$1WE", "$1T2+02001.00", "$1T1+0010.00",
    "$1T1+0001X.00", "$1T1+00004.00", "$1T2+00001.00", "$1we", "#1WE00", "$1WE",
    "$1SU7B050000", "$1SU80050000", "$1SU31050100", "$1WE", "$1SP24"};
  logic [7:0] code[] = '{ERR_WP, RESP_OK, ERR_VAL, ERR_SYN, ERR_VAL, RESP_OK, ERR_WP,
    ERR_CMD, ERR_CSUM, RESP_OK, ERR_ADDR, ERR_ADDR, RESP_OK, RESP_OK, RESP_OK};

  rkc_top #(.MS_CYCLES(10)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_parity_err(par), .open_channel(pl[0]),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_code(resp_code),
    .resp_addr(resp_addr), .rs485_char_valid(pl[1]), .rx_buf_empty(empty),
    .modem_tx_idle(idle), .modem_cts(cts), .modem_rts(rts), .tx_enable(txe));
  rkc_modem_model u_modem (.aclk(aclk), .aresetn(aresetn), .modem_rts(rts), .tx_enable(txe),
    .load(pl[2]), .load_n(4'h3), .cts_on(cts_on), .modem_cts(cts), .rx_buf_empty(empty),
    .modem_tx_idle(idle));

  always #2.5 aclk = ~aclk;

  task automatic wrap_up;
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic gate(input logic ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (waited = 0; waited < 50 && bvalid !== 1'h1; waited++) begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end
    gate(bvalid === 1'h1);
    `CHK("bresp", AXI_OKAY, bresp)
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (waited = 0; waited < 50 && rvalid !== 1'h1; waited++) begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end
    gate(rvalid === 1'h1);
    rready <= 1'h0;
    rd = rdata;
    rr = rresp;
  endtask

  task automatic pulse(input int b);
    @(posedge aclk);
    pl[b] <= 1'h1;
    @(posedge aclk);
    pl <= 3'h0;
  endtask

  task automatic getresp(input logic [7:0] ec);
    `WT(resp_valid, 20)
    `CHK("resp_code", ec, resp_code)
    `CHK("resp_err", ec != RESP_OK, resp_err)
    `CHK("resp_addr", 8'h31, resp_addr)
  endtask

  task automatic cmd(input string s, input logic [7:0] ec);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge aclk);
      cmd_valid <= 1'h1;
      cmd_data <= (i == s.len()) ? CH_CR : 8'(s[i]);
    end
    @(posedge aclk);
    cmd_valid <= 1'h0;
    getresp(ec);
  endtask

  // appends the two-digit upper-case sum of all characters
  function automatic string cs(input string s);
    logic [7:0] x;
    string t;
    x = 8'h00;
    foreach (s[i]) x += s[i];
    t = $sformatf("%h", x);
    return {s, t.toupper()};
  endfunction

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    axr(REG_SETUP);
    `CHK("setup_reset", SETUP_RST, rd)
    axr(8'h40);
    `CHK("unmapped", AXI_SLVERR, rr)
    foreach (seq[i]) cmd(seq[i], code[i]);
    axr(REG_T2);
    `CHK("t2_kept", {21'h0, T2_RST}, rd)
    pulse(0);
    getresp(ERR_CMD);
    cmd("$1WE", RESP_OK);
    cmd("$1SP40", RESP_OK);
    pulse(0);
    getresp(RESP_OK);
    cmd("@1WE", RESP_OK);
    par <= 1'h1;
    cmd("$1WE", RESP_OK);
    axw(REG_SETUP, 32'h31250100);
    cmd("$1WE", ERR_PAR);
    par <= 1'h0;
    repeat (4) begin
      k = $unsigned($random(seed)) % 3;
      v = $unsigned($random(seed)) % 2001;
      cmd("$1WE", RESP_OK);
      cmd(cs($sformatf("#1T%0d+%05d.00", k + 1, v)), RESP_OK);
      axr(REG_T1 + 8'(4 * k));
      `CHK("delay_value", 32'(v), rd)
    end
    axw(REG_T1, 32'h4);
    axw(REG_T2, 32'h3);
    axw(REG_T3, 32'h2);
    pulse(2);
    pulse(1);
    repeat (25) @(posedge aclk);
    pulse(1);
    `WT(rts, 100)
    `CHK("dead_restart", 1'h1, waited >= 28)
    `CHK("settle_gate", 1'h0, txe)
    `WT(txe, 100)
    `CHK("settle_len", 1'h1, waited >= 17)
    `WT(rts === 1'h0, 200)
    `CHK("drain_first", 1'h1, waited >= 30)
    `CHK("unkey_tx", 1'h0, txe)
    `CHK("unkey_empty", 1'h1, empty)
    axw(REG_T2, 32'h7d0);
    axw(REG_T3, 32'h14);
    cts_on <= 1'h1;
    pulse(2);
    pulse(1);
    `WT(rts, 100)
    `WT(txe, 20)
    `WT(idle === 1'h1 && empty === 1'h1, 100)
    repeat (100) @(posedge aclk);
    pulse(2);
    @(posedge aclk);
    `WT(empty, 100)
    `CHK("hold_keyed", 1'h1, rts)
    `WT(rts === 1'h0, 300)
    `CHK("hold_restart", 1'h1, waited >= 180)
    wrap_up();
  end
endmodule
`default_nettype wire
